// file: include/fcl_consts.vh
`ifndef FCL_CONSTS_VH
`define FCL_CONSTS_VH

// configuration page layout
`define FCL_PAGE_BYTES 512
`define FCL_ADDR_W 9
`define FCL_OFS_PARAM 9'h000
`define FCL_PARAM_BYTES 32
`define FCL_OFS_UPC 9'h020
`define FCL_OFS_RSV0 9'h021
`define FCL_OFS_LOCK 9'h023
`define FCL_OFS_DEBUG 9'h024
`define FCL_OFS_RSV1 9'h025
`define FCL_OFS_USER 9'h100
`define FCL_BYTE_ERASED 8'hFF

// code space protection
`define FCL_CODE_PAGES 32
`define FCL_LAST_PAGE 5'h1F
`define FCL_PAGE_SHIFT 9

// boot parity window in data memory
`define FCL_PAR_BYTES 16

// reset values of the loaded settings
`define FCL_RST_UPC 8'hFF
`define FCL_RST_LOCK 1'b1
`define FCL_RST_DEBUG 1'b0
`define FCL_RST_READY_N 1'b1
`define FCL_RST_BFP 1'b0

`endif

// file: logic/fcl_loader.v
`timescale 1ns/1ps
`include "fcl_consts.vh"

module fcl_loader #(
    parameter PAGE_W = 5,            // code page index width
    parameter DMEM_AW = 10,          // data memory byte address width
    parameter CODE_AW = 14           // code space address width
) (
    input wire CLK_IN,               // system clock, 40 MHz
    input wire RST_IN,               // synchronous reset, active high
    input wire CE_IN,                // clock enable, freezes state when low
    output reg [8:0] CFG_ADDR_OUT,   // configuration page read address
    output reg CFG_RD_OUT,           // configuration page read strobe
    input wire [7:0] CFG_DATA_IN,    // configuration byte, valid while strobe stands
    output reg [DMEM_AW-1:0] DMEM_ADDR_OUT, // data memory read address
    output reg DMEM_RD_OUT,          // data memory read strobe
    input wire [7:0] DMEM_DATA_IN,   // data byte, valid while strobe stands
    input wire [PAGE_W-1:0] CPU_PAGE_IN, // page of processor write or erase
    input wire CPU_WR_REQ_IN,        // processor write or erase request
    output wire CPU_WR_OK_OUT,       // processor request may proceed
    input wire SPI_MAIN_REQ_IN,      // SPI main block read, erase or program
    input wire SPI_IS_READ_IN,       // SPI request is a read
    output wire SPI_MAIN_OK_OUT,     // SPI main block access allowed
    output wire SPI_TO_PAGE_OUT,     // SPI erase or program goes to config page
    input wire SPI_PAGE_WR_REQ_IN,   // SPI erase or program of config page
    output wire SPI_PAGE_WR_OK_OUT,  // config page write allowed
    input wire SPI_LOCK_CMD_IN,      // dedicated lock command pulse
    input wire SPI_BULK_ERASE_IN,    // bulk erase command pulse
    output wire ERASE_MAIN_OUT,      // bulk erase of main block
    output wire ERASE_PAGE_OUT,      // bulk erase of config page
    input wire PAGE_SEL_SET_IN,      // write to page select enable
    input wire PAGE_SEL_VAL_IN,      // value written to page select enable
    output reg [7:0] UPC_OUT,        // unprotected page count register
    output reg LOCK_OUT,             // readback lock active
    output reg DEBUG_EN_OUT,         // hardware debug and JTAG enabled
    output reg BOOT_PROT_OUT,        // boot from protected flag
    output reg READY_N_OUT,          // flash ready flag, active low
    output reg FETCH_EN_OUT,         // processor may fetch code
    output reg [CODE_AW-1:0] BOOT_ADDR_OUT, // first fetch address
    output reg PAGE_SEL_OUT          // page select enable
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_CFG = 5'h02;
    localparam [4:0] ST_PAR = 5'h04;
    localparam [4:0] ST_BOOT = 5'h08;
    localparam [4:0] ST_RUN = 5'h10;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [4:0] cnt_q;
    reg rd_wait_q;
    reg [8:0] last_addr_q;
    reg par_q;
    reg lock_written_q;
    wire prot;
    wire [PAGE_W-1:0] first_prot;

    // odd parity of one byte
    function par8;
        input [7:0] b;
        begin
            par8 = ^b;
        end
    endfunction

    fcl_protect #(
        .PAGE_W(PAGE_W)
    ) u_prot (
        .upc_in(UPC_OUT),
        .page_in(CPU_PAGE_IN),
        .prot_out(prot),
        .first_out(first_prot)
    );

    // boot sequence sequencing
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: state_d = ST_CFG;
            ST_CFG: if (rd_wait_q && last_addr_q == `FCL_OFS_DEBUG) state_d = ST_PAR;
            ST_PAR: if (rd_wait_q && cnt_q == 5'd`FCL_PAR_BYTES) state_d = ST_BOOT;
            ST_BOOT: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_IDLE;
        endcase
    end

    // next configuration byte to read; reserved bytes at 0x21 are skipped
    function [8:0] next_cfg_addr;
        input [8:0] a;
        begin
            next_cfg_addr = (a == `FCL_OFS_UPC) ? `FCL_OFS_LOCK : `FCL_OFS_DEBUG;
        end
    endfunction

    // capture edges: a byte is taken while its strobe still stands
    wire cap_cfg = (state_q == ST_CFG) && rd_wait_q;
    wire cfg_last = cap_cfg && (last_addr_q == `FCL_OFS_DEBUG);
    wire cap_par = (state_q == ST_PAR) && rd_wait_q && (cnt_q != 5'd`FCL_PAR_BYTES);
    wire par_last = cap_par && (cnt_q == 5'd`FCL_PAR_BYTES - 5'd1);
    wire run = (state_q == ST_RUN);

    // boot state register
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_q <= ST_IDLE;
        end else if (CE_IN) begin
            state_q <= state_d;
        end
    end

    // read marker, high in each cycle whose closing edge takes a byte
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            rd_wait_q <= 1'b0;
        end else if (CE_IN) begin
            rd_wait_q <= (state_q == ST_IDLE) || cap_cfg || cap_par;
        end
    end

    // configuration page strobe and address
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            CFG_ADDR_OUT <= 9'h000;
            CFG_RD_OUT <= 1'b0;
            last_addr_q <= 9'h000;
        end else if (CE_IN) begin
            CFG_RD_OUT <= 1'b0;
            if (state_q == ST_IDLE) begin
                CFG_ADDR_OUT <= `FCL_OFS_UPC;
                last_addr_q <= `FCL_OFS_UPC;
                CFG_RD_OUT <= 1'b1;
            end else if (cap_cfg && !cfg_last) begin
                CFG_ADDR_OUT <= next_cfg_addr(last_addr_q);
                last_addr_q <= next_cfg_addr(last_addr_q);
                CFG_RD_OUT <= 1'b1;
            end
        end
    end

    // parity scan of the top data bytes, exactly one capture per byte
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            DMEM_ADDR_OUT <= {DMEM_AW{1'b0}};
            DMEM_RD_OUT <= 1'b0;
            cnt_q <= 5'h00;
            par_q <= 1'b0;
        end else if (CE_IN) begin
            DMEM_RD_OUT <= 1'b0;
            if (cfg_last) begin
                DMEM_ADDR_OUT <= {DMEM_AW{1'b1}} - 5'd`FCL_PAR_BYTES + 1'b1;
                DMEM_RD_OUT <= 1'b1;
                cnt_q <= 5'h00;
                par_q <= 1'b0;
            end else if (cap_par) begin
                par_q <= par_q ^ par8(DMEM_DATA_IN);
                cnt_q <= cnt_q + 5'h01;
                if (!par_last) begin
                    DMEM_ADDR_OUT <= DMEM_ADDR_OUT + 1'b1;
                    DMEM_RD_OUT <= 1'b1;
                end
            end
        end
    end

    // loaded settings and run-time commands
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            UPC_OUT <= `FCL_RST_UPC;
            LOCK_OUT <= `FCL_RST_LOCK;
            DEBUG_EN_OUT <= `FCL_RST_DEBUG;
            READY_N_OUT <= `FCL_RST_READY_N;
            PAGE_SEL_OUT <= 1'b0;
            lock_written_q <= 1'b0;
        end else if (CE_IN) begin
            if (cap_cfg && last_addr_q == `FCL_OFS_UPC)
                UPC_OUT <= CFG_DATA_IN;
            if (cap_cfg && last_addr_q == `FCL_OFS_LOCK)
                LOCK_OUT <= (CFG_DATA_IN != `FCL_BYTE_ERASED);
            if (cfg_last) begin
                DEBUG_EN_OUT <= (CFG_DATA_IN != `FCL_BYTE_ERASED);
                READY_N_OUT <= 1'b0;
            end
            if (run && PAGE_SEL_SET_IN)
                PAGE_SEL_OUT <= PAGE_SEL_VAL_IN;
            // lock set once, cleared only by bulk erase
            if (run && SPI_BULK_ERASE_IN) begin
                LOCK_OUT <= 1'b0;
                lock_written_q <= 1'b0;
                UPC_OUT <= `FCL_BYTE_ERASED;
                DEBUG_EN_OUT <= 1'b0;
            end else if (run && SPI_LOCK_CMD_IN && !lock_written_q && !LOCK_OUT) begin
                LOCK_OUT <= 1'b1;
                lock_written_q <= 1'b1;
            end
        end
    end

    // boot result, taken once the parity scan is complete
    always @(posedge CLK_IN) begin
        if (RST_IN) begin
            BOOT_PROT_OUT <= `FCL_RST_BFP;
            BOOT_ADDR_OUT <= {CODE_AW{1'b0}};
            FETCH_EN_OUT <= 1'b0;
        end else if (CE_IN && state_q == ST_BOOT) begin
            BOOT_PROT_OUT <= par_q;
            BOOT_ADDR_OUT <= par_q ?
                ({{(CODE_AW-PAGE_W){1'b0}}, first_prot} << `FCL_PAGE_SHIFT) :
                {CODE_AW{1'b0}};
            FETCH_EN_OUT <= 1'b1;
        end
    end

    // access gating
    assign CPU_WR_OK_OUT = CPU_WR_REQ_IN && !prot;
    assign SPI_MAIN_OK_OUT = SPI_MAIN_REQ_IN && !LOCK_OUT && !PAGE_SEL_OUT;
    assign SPI_TO_PAGE_OUT = PAGE_SEL_OUT && SPI_MAIN_REQ_IN && !SPI_IS_READ_IN;
    assign SPI_PAGE_WR_OK_OUT = SPI_PAGE_WR_REQ_IN && !LOCK_OUT;
    assign ERASE_MAIN_OUT = SPI_BULK_ERASE_IN && FETCH_EN_OUT;
    assign ERASE_PAGE_OUT = SPI_BULK_ERASE_IN && FETCH_EN_OUT;
endmodule // fcl_loader

// file: logic/fcl_protect.v
`timescale 1ns/1ps
`include "fcl_consts.vh"

// combinational page protection check for processor writes and erases
module fcl_protect #(
    parameter PAGE_W = 5
) (
    input wire [7:0] upc_in,          // unprotected page count
    input wire [PAGE_W-1:0] page_in,  // page addressed by processor
    output wire prot_out,             // page is protected
    output wire [PAGE_W-1:0] first_out // first protected page
);
    // 0xFF or any value of 32 and up leaves all pages open
    wire all_open = (upc_in == `FCL_BYTE_ERASED) || (upc_in >= `FCL_CODE_PAGES);
    assign prot_out = !all_open && ({3'h0, page_in} >= upc_in);
    assign first_out = all_open ? {PAGE_W{1'b0}} : upc_in[PAGE_W-1:0];
endmodule // fcl_protect

// file: tb/fcl_loader_chk.sv
`timescale 1ns/1ps
// port level checks on the configuration loader
module fcl_loader_chk #(parameter PAGE_W = 5, parameter CODE_AW = 14) (
    input wire CLK_IN, input wire RST_IN, input wire [PAGE_W-1:0] CPU_PAGE_IN,
    input wire CPU_WR_REQ_IN, input wire CPU_WR_OK_OUT, input wire SPI_MAIN_REQ_IN,
    input wire SPI_IS_READ_IN, input wire SPI_MAIN_OK_OUT, input wire SPI_TO_PAGE_OUT,
    input wire SPI_PAGE_WR_REQ_IN, input wire SPI_PAGE_WR_OK_OUT, input wire SPI_BULK_ERASE_IN,
    input wire ERASE_MAIN_OUT, input wire ERASE_PAGE_OUT, input wire [7:0] UPC_OUT,
    input wire LOCK_OUT, input wire BOOT_PROT_OUT, input wire READY_N_OUT,
    input wire FETCH_EN_OUT, input wire [CODE_AW-1:0] BOOT_ADDR_OUT, input wire PAGE_SEL_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    a_cpu_prot: assert property (
        CPU_WR_OK_OUT == (CPU_WR_REQ_IN && (UPC_OUT > 8'h1F || CPU_PAGE_IN < UPC_OUT)))
        else $error("cpu write permit wrong");
    a_spi_lock: assert property (
        SPI_MAIN_OK_OUT == (SPI_MAIN_REQ_IN && !LOCK_OUT && !PAGE_SEL_OUT))
        else $error("spi main permit wrong");
    a_page_wr: assert property (
        SPI_PAGE_WR_OK_OUT == (SPI_PAGE_WR_REQ_IN && !LOCK_OUT))
        else $error("page write permit wrong");
    a_to_page: assert property (
        SPI_TO_PAGE_OUT == (PAGE_SEL_OUT && SPI_MAIN_REQ_IN && !SPI_IS_READ_IN))
        else $error("page redirect wrong");
    a_bulk_both: assert property (
        ERASE_MAIN_OUT == (SPI_BULK_ERASE_IN && FETCH_EN_OUT) && ERASE_PAGE_OUT == ERASE_MAIN_OUT)
        else $error("bulk erase split wrong");
    a_boot_time: assert property ($fell(RST_IN) |-> ##[1:60] FETCH_EN_OUT)
        else $error("boot did not finish");
    a_ready_held: assert property ($fell(RST_IN) |-> READY_N_OUT [*4])
        else $error("ready flag fell early");
    a_fetch_ready: assert property (FETCH_EN_OUT |-> !READY_N_OUT)
        else $error("fetch before ready");
    a_boot_addr: assert property ($rose(FETCH_EN_OUT) |-> BOOT_ADDR_OUT ==
        ((BOOT_PROT_OUT && UPC_OUT < 8'h20) ? {UPC_OUT[4:0], 9'h000} : 14'h0000))
        else $error("boot address wrong");
    a_lock_kept: assert property (
        FETCH_EN_OUT && LOCK_OUT && !SPI_BULK_ERASE_IN |=> LOCK_OUT)
        else $error("lock cleared without bulk erase");
endmodule // fcl_loader_chk

// file: tb/fcl_mem_model.sv
`timescale 1ns/1ps
// configuration page and data memory seen by the loader
module fcl_mem_model (
    input wire clk_in, // system clock
    input wire [8:0] cfg_addr_in, // page byte address
    input wire cfg_rd_in, // page read strobe
    output reg [7:0] cfg_data_out, // page byte
    input wire [9:0] dm_addr_in, // data memory address
    input wire dm_rd_in, // data memory strobe
    output reg [7:0] dm_data_out, // data byte
    input wire [23:0] cfg_in, // count, lock and debug bytes
    input wire [127:0] dm_in // top 16 data bytes
);
    reg [7:0] cfg_v;
    reg [7:0] dm_v;
    // answer while the strobe stands, otherwise drive the inverse
    always @* begin
        cfg_v = 8'hFF;
        case (cfg_addr_in)
            9'h020: cfg_v = cfg_in[23:16];
            9'h023: cfg_v = cfg_in[15:8];
            9'h024: cfg_v = cfg_in[7:0];
            default: cfg_v = 8'hFF;
        endcase
        dm_v = dm_in[8*dm_addr_in[3:0] +: 8];
        cfg_data_out = cfg_rd_in ? cfg_v : ~cfg_v;
        dm_data_out = dm_rd_in ? dm_v : ~dm_v;
    end
endmodule // fcl_mem_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg clk = 1'b0, rst = 1'b1, cwr = 1'b0, sreq = 1'b0, srd = 1'b0, pwr = 1'b0;
    reg lck = 1'b0, bulk = 1'b0, psel = 1'b0, pval = 1'b0, el, ed, eb;
    reg [4:0] page = 5'h00;
    reg [7:0] eu, lb, db;
    reg ce = 1'b1;
    reg [13:0] ea;
    reg [23:0] cfg = 24'hFFFFFF;
    reg [127:0] dm = 128'h0;
    wire [8:0] ca; wire cr; wire [7:0] cd; wire [9:0] da; wire dr; wire [7:0] dd;
    wire wok, mok, tpg, pok, em, ep, lo, de, bp, rn, fe, ps;
    wire [7:0] upc; wire [13:0] ba;
    integer fail_count = 0, checks = 0, i, k, n;
    // system clock, 25 ns period
    initial forever #12.5 clk = ~clk;
    fcl_loader i_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .CFG_ADDR_OUT(ca),
        .CFG_RD_OUT(cr), .CFG_DATA_IN(cd), .DMEM_ADDR_OUT(da), .DMEM_RD_OUT(dr),
        .DMEM_DATA_IN(dd), .CPU_PAGE_IN(page), .CPU_WR_REQ_IN(cwr), .CPU_WR_OK_OUT(wok),
        .SPI_MAIN_REQ_IN(sreq), .SPI_IS_READ_IN(srd), .SPI_MAIN_OK_OUT(mok),
        .SPI_TO_PAGE_OUT(tpg), .SPI_PAGE_WR_REQ_IN(pwr), .SPI_PAGE_WR_OK_OUT(pok),
        .SPI_LOCK_CMD_IN(lck), .SPI_BULK_ERASE_IN(bulk), .ERASE_MAIN_OUT(em),
        .ERASE_PAGE_OUT(ep), .PAGE_SEL_SET_IN(psel), .PAGE_SEL_VAL_IN(pval), .UPC_OUT(upc),
        .LOCK_OUT(lo), .DEBUG_EN_OUT(de), .BOOT_PROT_OUT(bp), .READY_N_OUT(rn),
        .FETCH_EN_OUT(fe), .BOOT_ADDR_OUT(ba), .PAGE_SEL_OUT(ps));
    fcl_mem_model i_mem (.clk_in(clk), .cfg_addr_in(ca), .cfg_rd_in(cr), .cfg_data_out(cd),
        .dm_addr_in(da), .dm_rd_in(dr), .dm_data_out(dd), .cfg_in(cfg), .dm_in(dm));
    // compare one value and count it
    task chk(input [31:0] got, input [31:0] exp); begin
        checks = checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end endtask
    // print counts and verdict, then stop
    task results; begin
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    end endtask
    // reset for six cycles and wait for fetch enable
    task boot; begin
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        n = 0;
        while (fe !== 1'b1 && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
        if (n == 100) begin
            fail_count = fail_count + 1;
            results;
        end
    end endtask
    // boundary and random configurations, each booted and exercised
    initial begin
        n = $urandom(32'h28723b64);
        for (k = 0; k < 12; k = k + 1) begin
            eu = (k < 5) ? 40'h0C201F00FF >> (8 * k) : $urandom;
            lb = k[0] ? 8'h5A ^ $urandom : 8'hFF;
            db = k[1] ? 8'hFF : 8'h3C ^ $urandom;
            cfg = {eu, lb, db};
            dm = {$urandom, $urandom, $urandom, $urandom};
            el = cfg[15:8] != 8'hFF;
            ed = cfg[7:0] != 8'hFF;
            eb = ^dm;
            ea = (eb && eu < 8'h20) ? {eu[4:0], 9'h000} : 14'h0000;
            boot;
            chk(upc, eu);
            chk(lo, el);
            chk(de, ed);
            chk(bp, eb);
            chk(ba, ea);
            chk(rn, 1'b0);
            for (i = 0; i < 32; i = i + 1) begin
                page = i;
                cwr = $urandom;
                sreq = 1'b1;
                pwr = 1'b1;
                srd = $urandom;
                @(negedge clk);
                chk(wok, cwr && (eu > 8'h1F || i < eu));
                chk({mok, pok}, {2{!el}});
            end
            lck = 1'b1;
            @(negedge clk) lck = 1'b0;
            chk(lo, 1'b1);
            bulk = 1'b1;
            #2 chk({em, ep}, 2'b11);
            @(negedge clk) bulk = 1'b0;
            chk({lo, de, upc}, 10'h0FF);
            {psel, pval, srd} = 3'b110;
            @(negedge clk) psel = 1'b0;
            #2 chk({tpg, mok}, 2'b10);
            {ce, lck} = 2'b01;
            @(negedge clk) {ce, lck} = 2'b10;
            chk(lo, 1'b0);
            {sreq, pwr, cwr} = 3'b000;
            $display("test %0d done", k);
        end
        results;
    end
endmodule // testbench
bind fcl_loader fcl_loader_chk #(.PAGE_W(PAGE_W), .CODE_AW(CODE_AW)) i_chk (.*);
